// ---- logic/sw_eeprom_defs.vh ----
// Constants of the single-wire EEPROM command decoder and write sequencer.
// Assumes a 20 MHz core clock; included by the design file only.
`ifndef SW_EEPROM_DEFS_VH
`define SW_EEPROM_DEFS_VH

// Opcodes carried in bits 7..4 of the device address byte.
`define OP_ARRAY        4'ha
`define OP_SECREG       4'hb
`define OP_LOCK         4'h2
`define OP_ZONE         4'h7
`define OP_FREEZE       4'h1
`define OP_IDENT        4'hc
`define OP_STD_SPEED    4'hd
`define OP_HIGH_SPEED   4'he

// Field positions of the device address byte.
`define DEV_OP_MSB      7
`define DEV_OP_LSB      4
`define DEV_SA_MSB      3
`define DEV_SA_LSB      1
`define DEV_RW_BIT      0

// Memory address byte: low seven bits used, row and column split.
`define ROW_ADDR_TOP_BIT 6
`define ROW_ADDR_LOW_BIT 3
`define COL_MSB          2

// Array geometry.
`define ARRAY_DEPTH     128
`define PAGE_BYTES      8
`define SECREG_DEPTH    32
`define SECREG_USER_LO  16
`define ZONE_COUNT      4

// Reset values, then the high address nibbles of the zone and lock commands.
`define RST_HIGH_SPEED  1'b1
`define RST_ZONE_RO     4'h0
`define ZONE_ADDR_HI    4'h0
`define LOCK_ADDR_HI    4'h6

// Timing: write cycle time in microseconds and its cycle count at 20 MHz.
`define CLK_MHZ         20
`define WRITE_TIME_US   5000
`define WRITE_CYCLES    (`WRITE_TIME_US * `CLK_MHZ)
// Discharge abort time in microseconds; longest time, rounded down.
`define DSCHG_TIME_US   150
`define DSCHG_CYCLES    (`DSCHG_TIME_US * `CLK_MHZ)

`endif

// ---- logic/sw_eeprom_cmd.v ----
// Command decoder and write sequencer of a single-wire serial EEPROM.
// Assumes a bit-level framer on the same clock that delivers whole bytes
// with a valid/ready pair, a start and a stop pulse, and the raw line level.
//
// Functional notes
// - opcode 1010 routes the transaction to the main array.
// - opcode 1011 routes the transaction to the security register.
// - opcode 0010 permanently locks the user part of the security register.
// - opcode 0111 writes the zone read-only configuration.
// - opcode 0001 freezes the zone configuration for good.
// - opcode 1100 returns maker, density and revision data.
// - opcode 1101 selects or queries standard speed mode.
// - opcode 1110 selects or queries high speed; high speed after reset.
// - main array is four zones of 256 bits, each lockable read-only.
// - stop not right after a whole data byte aborts the write.
// - commands during programming are ignored and answered with busy nack.
// - line low beyond discharge time terminates the programming cycle.
// - ack after device address, memory address and each data byte.
// - stop after last data byte starts a bounded self-timed write.
// - page write takes one to eight bytes of one row.
// - after the first data byte every further byte is acked, wrapping over the page.
// - only low three address bits increment, wrapping within the page.
// - an interrupted cycle corrupts at most the byte being programmed.
// - address byte holds opcode, slave address and direction; mismatch silent.
// - memory address byte ignores its top bit.
`timescale 1ns/1ps
`include "sw_eeprom_defs.vh"

module sw_eeprom_cmd #(
    parameter WRITE_CYCLES = `WRITE_CYCLES,
    parameter DSCHG_CYCLES = `DSCHG_CYCLES
) (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire [2:0] i_slave_addr,
    input  wire       i_line,
    input  wire       i_start,
    input  wire       i_stop,
    input  wire       i_byte_valid,
    input  wire [7:0] i_byte,
    output reg        o_byte_ready,
    output reg        o_ack_valid,
    output reg        o_ack_nack,
    input  wire       i_ack_ready,
    output reg        o_busy,
    output reg        o_high_speed,
    output reg  [3:0] o_zone_ro,
    output reg        o_zone_frozen,
    output reg        o_sec_locked,
    output reg        o_ident_req,
    output reg        o_read_req,
    output reg        o_read_secreg,
    output reg  [6:0] o_read_addr,
    output reg        o_wr_corrupt
);

    // Sequencer states.
    localparam ST_IDLE = 3'h0;
    localparam ST_DEV  = 3'h1;
    localparam ST_MEM  = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_PROG = 3'h4;
    localparam ST_SKIP = 3'h5;

    // Targets of a pending write.
    localparam TG_ARRAY  = 2'h0;
    localparam TG_SECREG = 2'h1;
    localparam TG_LOCK   = 2'h2;
    localparam TG_ZONE   = 2'h3;

    reg [2:0]  state_ff;
    reg [1:0]  target_ff;
    reg [6:0]  addr_ff;
    reg [3:0]  count_ff;
    reg        at_boundary_ff;
    reg [7:0]  page_ff [0:`PAGE_BYTES-1];
    reg [`PAGE_BYTES-1:0] page_vld_ff;
    reg [7:0]  array_ff [0:`ARRAY_DEPTH-1];
    reg [7:0]  secreg_ff [0:`SECREG_DEPTH-1];
    reg [6:0]  base_ff;
    reg [16:0] prog_cnt_ff;
    reg [15:0] low_cnt_ff;
    reg        line_s1_ff;
    reg        line_s2_ff;
    reg        commit_ff;

    // Two-entry skid buffer between the framer and the decoder.
    reg [7:0]  buf_data_ff [0:1];
    reg        buf_head_ff;
    reg        buf_tail_ff;
    reg [1:0]  buf_count_ff;
    wire       buf_out_valid = (buf_count_ff != 2'h0);
    wire [7:0] buf_out = buf_data_ff[buf_head_ff];
    wire       ack_free = !o_ack_valid || i_ack_ready;
    wire       take = buf_out_valid && ack_free;
    wire       push = i_byte_valid && o_byte_ready;

    // Zone number of an array address: 32 bytes per 256-bit zone.
    function [1:0] zone_of;
        input [6:0] a;
        begin
            zone_of = a[6:5];
        end
    endfunction

    // Address decoding check used on the device address byte.
    function dev_match;
        input [7:0] b;
        input [2:0] sa;
        begin
            dev_match = (b[`DEV_SA_MSB:`DEV_SA_LSB] == sa);
        end
    endfunction

    // Line level passes two flip-flops before the abort timer looks at it.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            line_s1_ff <= 1'b1;
            line_s2_ff <= 1'b1;
        end else begin
            line_s1_ff <= i_line;
            line_s2_ff <= line_s1_ff;
        end
    end

    // Buffer bookkeeping; ready drops when both entries are full.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            buf_head_ff  <= 1'b0;
            buf_tail_ff  <= 1'b0;
            buf_count_ff <= 2'h0;
            o_byte_ready <= 1'b1;
        end else begin
            if (push) begin
                buf_data_ff[buf_tail_ff] <= i_byte;
                buf_tail_ff <= ~buf_tail_ff;
            end
            if (take) begin
                buf_head_ff <= ~buf_head_ff;
            end
            case ({push, take})
                2'b10: buf_count_ff <= buf_count_ff + 2'h1;
                2'b01: buf_count_ff <= buf_count_ff - 2'h1;
                default: buf_count_ff <= buf_count_ff;
            endcase
            o_byte_ready <= !((buf_count_ff == 2'h2 && !take) ||
                              (buf_count_ff == 2'h1 && push && !take));
        end
    end

    integer i;

    // Main command sequencer.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff       <= ST_IDLE;
            target_ff      <= TG_ARRAY;
            addr_ff        <= 7'h00;
            base_ff        <= 7'h00;
            count_ff       <= 4'h0;
            at_boundary_ff <= 1'b0;
            page_vld_ff    <= {`PAGE_BYTES{1'b0}};
            prog_cnt_ff    <= 17'h00000;
            low_cnt_ff     <= 16'h0000;
            commit_ff      <= 1'b0;
            o_ack_valid    <= 1'b0;
            o_ack_nack     <= 1'b0;
            o_busy         <= 1'b0;
            o_high_speed   <= `RST_HIGH_SPEED;
            o_zone_ro      <= `RST_ZONE_RO;
            o_zone_frozen  <= 1'b0;
            o_sec_locked   <= 1'b0;
            o_ident_req    <= 1'b0;
            o_read_req     <= 1'b0;
            o_read_secreg  <= 1'b0;
            o_read_addr    <= 7'h00;
            o_wr_corrupt   <= 1'b0;
        end else begin
            o_ident_req <= 1'b0;
            o_read_req  <= 1'b0;
            if (o_ack_valid && i_ack_ready) begin
                o_ack_valid <= 1'b0;
            end
            case (state_ff)
                ST_IDLE, ST_SKIP: begin
                    if (i_start) begin
                        state_ff <= ST_DEV;
                    end else if (take) begin
                        state_ff <= ST_SKIP;
                    end
                end
                ST_DEV: begin
                    if (i_stop) begin
                        state_ff <= ST_IDLE;
                    end else if (take) begin
                        if (!dev_match(buf_out, i_slave_addr)) begin
                            state_ff <= ST_SKIP;
                        end else begin
                            o_ack_valid <= 1'b1;
                            o_ack_nack  <= 1'b0;
                            state_ff    <= ST_MEM;
                            case (buf_out[`DEV_OP_MSB:`DEV_OP_LSB])
                                `OP_ARRAY:  target_ff <= TG_ARRAY;
                                `OP_SECREG: target_ff <= TG_SECREG;
                                `OP_LOCK:   target_ff <= TG_LOCK;
                                `OP_ZONE:   target_ff <= TG_ZONE;
                                `OP_FREEZE: begin
                                    o_zone_frozen <= 1'b1;
                                    state_ff <= ST_SKIP;
                                end
                                `OP_IDENT: begin
                                    o_ident_req <= 1'b1;
                                    state_ff <= ST_SKIP;
                                end
                                `OP_STD_SPEED: begin
                                    if (buf_out[`DEV_RW_BIT])
                                        o_ack_nack <= o_high_speed;
                                    else
                                        o_high_speed <= 1'b0;
                                    state_ff <= ST_SKIP;
                                end
                                `OP_HIGH_SPEED: begin
                                    if (buf_out[`DEV_RW_BIT])
                                        o_ack_nack <= !o_high_speed;
                                    else
                                        o_high_speed <= 1'b1;
                                    state_ff <= ST_SKIP;
                                end
                                default: begin
                                    o_ack_valid <= 1'b0;
                                    state_ff <= ST_SKIP;
                                end
                            endcase
                            if (buf_out[`DEV_RW_BIT] &&
                                (buf_out[7:4] == `OP_ARRAY ||
                                 buf_out[7:4] == `OP_SECREG)) begin
                                o_read_req    <= 1'b1;
                                o_read_secreg <= buf_out[4];
                                o_read_addr   <= addr_ff;
                                state_ff      <= ST_SKIP;
                            end
                        end
                    end
                end
                ST_MEM: begin
                    if (i_stop) begin
                        state_ff <= ST_IDLE;
                    end else if (take) begin
                        o_ack_valid <= 1'b1;
                        o_ack_nack  <= (target_ff == TG_LOCK) &&
                                       o_sec_locked;
                        addr_ff  <= buf_out[6:0];
                        base_ff  <= buf_out[6:0];
                        count_ff <= 4'h0;
                        page_vld_ff    <= {`PAGE_BYTES{1'b0}};
                        at_boundary_ff <= 1'b0;
                        state_ff <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (i_stop) begin
                        if (at_boundary_ff) begin
                            state_ff    <= ST_PROG;
                            o_busy      <= 1'b1;
                            prog_cnt_ff <= 17'h00000;
                            low_cnt_ff  <= 16'h0000;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end else if (take) begin
                        o_ack_valid <= 1'b1;
                        o_ack_nack  <= 1'b0;
                        if (target_ff == TG_SECREG &&
                            (o_sec_locked ||
                             addr_ff[4:0] < `SECREG_USER_LO)) begin
                            o_ack_nack <= 1'b1;
                            state_ff   <= ST_IDLE;
                        end else begin
                            page_ff[addr_ff[`COL_MSB:0]] <= buf_out;
                            page_vld_ff[addr_ff[`COL_MSB:0]] <= 1'b1;
                            addr_ff[`COL_MSB:0] <= addr_ff[`COL_MSB:0]
                                                   + 3'h1;
                            if (count_ff != 4'h8)
                                count_ff <= count_ff + 4'h1;
                            at_boundary_ff <= 1'b1;
                        end
                    end
                end
                ST_PROG: begin
                    if (take) begin
                        o_ack_valid <= 1'b1;
                        o_ack_nack  <= 1'b1;
                    end
                    if (!line_s2_ff)
                        low_cnt_ff <= low_cnt_ff + 16'h0001;
                    else
                        low_cnt_ff <= 16'h0000;
                    prog_cnt_ff <= prog_cnt_ff + 17'h00001;
                    if (low_cnt_ff == DSCHG_CYCLES[15:0]) begin
                        o_busy       <= 1'b0;
                        o_wr_corrupt <= 1'b1;
                        state_ff     <= ST_IDLE;
                    end else if (prog_cnt_ff == WRITE_CYCLES[16:0]) begin
                        o_busy    <= 1'b0;
                        commit_ff <= 1'b1;
                        state_ff  <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
            // Commit the loaded page one cycle after a clean cycle.
            if (commit_ff) begin
                commit_ff <= 1'b0;
                o_wr_corrupt <= 1'b0;
                case (target_ff)
                    TG_LOCK: o_sec_locked <= 1'b1;
                    // zone read-only bits
                    // The data byte sits in the column of its address.
                    TG_ZONE: if (!o_zone_frozen &&
                                 page_vld_ff[base_ff[`COL_MSB:0]])
                        o_zone_ro[base_ff[1:0]] <= o_zone_ro[base_ff[1:0]]
                            | page_ff[base_ff[`COL_MSB:0]][0];
                    default: ;
                endcase
            end
        end
    end

    always @(posedge i_clk) begin
        if (commit_ff) begin
            for (i = 0; i < `PAGE_BYTES; i = i + 1) begin
                if (page_vld_ff[i] && target_ff == TG_ARRAY &&
                    !o_zone_ro[zone_of({base_ff[6:3], i[2:0]})])
                    array_ff[{base_ff[6:3], i[2:0]}] <= page_ff[i];
                if (page_vld_ff[i] && target_ff == TG_SECREG)
                    secreg_ff[{base_ff[4:3], i[2:0]}] <= page_ff[i];
            end
        end
    end

endmodule // sw_eeprom_cmd

// ---- verif/sw_eeprom_cmd_assertions.sv ----
// Port checker of the single-wire EEPROM command decoder.
// Assumes one clock domain with an active-high asynchronous reset.
`timescale 1ns/1ps
module sw_eeprom_cmd_chk #(
    parameter WRITE_CYCLES = 20,
    parameter DSCHG_CYCLES = 5
) (
    input wire       i_clk,
    input wire       i_rst,
    input wire       i_line,
    input wire       i_stop,
    input wire       i_ack_ready,
    input wire       o_ack_valid,
    input wire       o_ack_nack,
    input wire       o_busy,
    input wire       o_high_speed,
    input wire [3:0] o_zone_ro,
    input wire       o_zone_frozen,
    input wire       o_sec_locked,
    input wire       o_wr_corrupt
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    reg [31:0] busy_cnt_ff;
    reg [31:0] low_cnt_ff;

    // Counts busy cycles and busy cycles with the line held low.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_cnt_ff <= 32'h0;
            low_cnt_ff  <= 32'h0;
        end else begin
            busy_cnt_ff <= o_busy ? busy_cnt_ff + 32'h1 : 32'h0;
            low_cnt_ff  <= (o_busy && !i_line) ? low_cnt_ff + 32'h1 : 32'h0;
        end
    end

    AST_RST_SPEED: assert property (
        $fell(i_rst) |-> o_high_speed && !o_busy)
        else $error("fast mode or idle missing after reset");
    AST_ACK_HOLD: assert property (
        o_ack_valid && !i_ack_ready |=> o_ack_valid && $stable(o_ack_nack))
        else $error("answer dropped before it was taken");
    AST_BUSY_START: assert property (
        $rose(o_busy) |-> $past(i_stop))
        else $error("programming began without a stop");
    AST_BUSY_BOUND: assert property (
        o_busy |-> busy_cnt_ff <= WRITE_CYCLES)
        else $error("programming ran past its time");
    AST_BUSY_NACK: assert property (
        o_busy && o_ack_valid |-> o_ack_nack)
        else $error("byte acknowledged while programming");
    AST_ZONE_KEEP: assert property (
        (o_zone_ro & $past(o_zone_ro)) == $past(o_zone_ro))
        else $error("read-only zone became writable");
    AST_FROZEN_HOLD: assert property (
        o_zone_frozen |=> o_zone_frozen && $stable(o_zone_ro))
        else $error("zone state changed after freeze");
    AST_LOCK_HOLD: assert property (
        o_sec_locked |=> o_sec_locked)
        else $error("security lock was released");
    AST_CORRUPT_CAUSE: assert property (
        $rose(o_wr_corrupt) |-> $past(o_busy))
        else $error("corruption flagged outside programming");
    AST_LONG_LOW: assert property (
        o_busy |-> low_cnt_ff <= DSCHG_CYCLES + 4)
        else $error("long low line did not end programming");
    AST_SHORT_LOW: assert property (
        o_busy && $fell(i_line) ##1 i_line |-> (!$rose(o_wr_corrupt))[*4])
        else $error("short low pulse ended programming");
endmodule // sw_eeprom_cmd_chk

bind sw_eeprom_cmd sw_eeprom_cmd_chk #(
    .WRITE_CYCLES(WRITE_CYCLES),
    .DSCHG_CYCLES(DSCHG_CYCLES)
) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_line(i_line), .i_stop(i_stop),
    .i_ack_ready(i_ack_ready), .o_ack_valid(o_ack_valid),
    .o_ack_nack(o_ack_nack), .o_busy(o_busy), .o_high_speed(o_high_speed),
    .o_zone_ro(o_zone_ro), .o_zone_frozen(o_zone_frozen),
    .o_sec_locked(o_sec_locked), .o_wr_corrupt(o_wr_corrupt)
);

// ---- verif/sw_framer_model.sv ----
// Behavioural bit framer standing between the bus master and the block.
// Assumes the bench calls its tasks one at a time on the block's clock.
`timescale 1ns/1ps
module sw_framer_model (
    input  wire       i_clk,
    input  wire       i_byte_ready,
    input  wire       i_ack_valid,
    input  wire       i_ack_nack,
    output reg        o_start,
    output reg        o_stop,
    output reg        o_byte_valid,
    output reg  [7:0] o_byte,
    output reg        o_ack_ready,
    output reg        o_line
);
    // Idle levels: line released high, no request pending.
    initial begin
        o_start = 1'b0;
        o_stop = 1'b0;
        o_byte_valid = 1'b0;
        o_byte = 8'h00;
        o_ack_ready = 1'b0;
        o_line = 1'b1;
    end

    task pulse(input logic stop);
        @(posedge i_clk);
        #1;
        o_start = !stop;
        o_stop = stop;
        @(posedge i_clk);
        #1;
        o_start = 1'b0;
        o_stop = 1'b0;
    endtask

    // Offers one whole byte until the buffer takes it.
    task push(input logic [7:0] b);
        int n;
        @(posedge i_clk);
        #1;
        o_byte_valid = 1'b1;
        o_byte = b;
        n = 0;
        @(posedge i_clk);
        while (i_byte_ready !== 1'b1 && n < 50) begin
            n++;
            @(posedge i_clk);
        end
        #1;
        o_byte_valid = 1'b0;
        o_byte = ~b;
    endtask

    // Takes one answer after a delay: 0 ack, 1 nack, 2 none.
    task take_ack(input int slow, output logic [1:0] r);
        int n;
        repeat (slow) @(posedge i_clk);
        #1;
        o_ack_ready = 1'b1;
        r = 2'd2;
        for (n = 0; n < 8 && r == 2'd2; n++) begin
            @(posedge i_clk);
            if (i_ack_valid === 1'b1) r = {1'b0, i_ack_nack};
        end
        #1;
        o_ack_ready = 1'b0;
    endtask

    task line_low(input int n);
        @(posedge i_clk);
        #1;
        o_line = 1'b0;
        repeat (n) @(posedge i_clk);
        #1;
        o_line = 1'b1;
    endtask
endmodule // sw_framer_model

// ---- verif/single_wire_eeprom_opcode_write_bench.sv ----
// Self-checking bench of the single-wire EEPROM command decoder.
// Assumes the framer model drives every byte-side input of the block.
`timescale 1ns/1ps
module single_wire_eeprom_opcode_write_bench;
    localparam int WC = 20;
    localparam logic [6:0] SPD [6] = '{7'h68, 7'h6c, 7'h76, 7'h71,
                                       7'h75, 7'h6f};
    localparam logic [6:0] RDT [3] = '{7'h64, 7'h52, 7'h5b};
    logic       i_clk, i_rst, saw_id, saw_rd, rd_sec;
    wire        start, stop, byte_valid, ack_ready, line, byte_ready;
    wire        ack_valid, ack_nack, busy, hs, frozen, locked, corrupt;
    wire        ident_req, read_req, read_secreg;
    wire  [7:0] byt;
    wire  [3:0] zone_ro;
    logic [1:0] r;
    logic [2:0] slave_addr;
    wire  [6:0] read_addr;
    int         i, n, cyc, err_count, n_checks;

    sw_eeprom_cmd #(.WRITE_CYCLES(WC), .DSCHG_CYCLES(5)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_slave_addr(slave_addr),
        .i_line(line),
        .i_start(start), .i_stop(stop), .i_byte_valid(byte_valid),
        .i_byte(byt), .o_byte_ready(byte_ready), .o_ack_valid(ack_valid),
        .o_ack_nack(ack_nack), .i_ack_ready(ack_ready), .o_busy(busy),
        .o_high_speed(hs), .o_zone_ro(zone_ro), .o_zone_frozen(frozen),
        .o_sec_locked(locked), .o_ident_req(ident_req),
        .o_read_req(read_req), .o_read_secreg(read_secreg),
        .o_read_addr(read_addr), .o_wr_corrupt(corrupt));
    sw_framer_model u_fr (
        .i_clk(i_clk), .i_byte_ready(byte_ready), .i_ack_valid(ack_valid),
        .i_ack_nack(ack_nack), .o_start(start), .o_stop(stop),
        .o_byte_valid(byte_valid), .o_byte(byt), .o_ack_ready(ack_ready),
        .o_line(line));

    // Clock of 50 ns period.
    always #25 i_clk = ~i_clk;

    // Remembers read pulses and cuts a hung run short.
    always @(posedge i_clk) begin
        if (ident_req === 1'b1) saw_id <= 1'b1;
        if (read_req === 1'b1) begin
            saw_rd <= 1'b1;
            rd_sec <= read_secreg;
        end
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    function automatic logic [7:0] dev(input logic [3:0] op, input logic rw);
        return {op, slave_addr, rw};
    endfunction

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Sends a byte and compares its answer; 3 skips the compare.
    task xfer(input logic [7:0] b, input logic [1:0] exp);
        logic [1:0] a;
        u_fr.push(b);
        u_fr.take_ack(0, a);
        if (exp != 2'd3) check(a, exp);
    endtask

    task wait_idle();
        n = 0;
        repeat (2) @(posedge i_clk);
        while (busy !== 1'b0 && n < 60) begin
            @(posedge i_clk);
            n++;
        end
        repeat (2) @(posedge i_clk);
        #1;
        check(busy, 1'b0);
    endtask

    // Counts the cycles of the programming cycle that follows a stop.
    task prog();
        u_fr.pulse(1);
        n = 0;
        while (busy !== 1'b1 && n < 4) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 99) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(n, WC + 1);
    endtask

    task wr_start(input logic [3:0] op, input logic [7:0] mem);
        u_fr.pulse(0);
        xfer(dev(op, 1'b0), 2'd0);
        xfer(mem, 2'd0);
    endtask

    task cmd(input logic [3:0] op, input logic [7:0] mem,
             input logic [7:0] dat, input logic [1:0] e);
        u_fr.pulse(0);
        xfer(dev(op, 1'b0), 2'd0);
        xfer(mem, (e == 2'd3) ? 2'd3 : 2'd0);
        xfer(dat, e);
        u_fr.pulse(1);
        wait_idle();
    endtask

    task done(input string name);
        $display("test %0s finished", name);
    endtask

    task end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence of tests.
    initial begin
        i_clk = 1'b0;
        i_rst = 1'b1;
        {saw_id, saw_rd, rd_sec} = 3'b000;
        {cyc, err_count, n_checks} = '0;
        slave_addr = 3'h5;
        repeat (10) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        check(hs, 1'b1);
        check({zone_ro, frozen, locked, corrupt, busy}, 8'h00);
        check(byte_ready, 1'b1);
        done("reset");
        u_fr.pulse(0);
        u_fr.push(dev(4'ha, 1'b0));
        u_fr.push(8'h85);
        u_fr.push(8'h3c);
        repeat (3) @(posedge i_clk);
        #1;
        check(byte_ready, 1'b0);
        for (i = 0; i < 3; i++) begin
            u_fr.take_ack(2, r);
            check(r, 2'd0);
        end
        prog();
        done("buffered byte write");
        wr_start(4'ha, 8'h10);
        xfer(8'h5a, 2'd0);
        u_fr.pulse(1);
        u_fr.pulse(0);
        xfer(dev(4'ha, 1'b0), 2'd1);
        u_fr.line_low(1);
        check(busy, 1'b1);
        wait_idle();
        check(corrupt, 1'b0);
        done("busy");
        for (i = 0; i < 2; i++) begin
            u_fr.pulse(0);
            xfer(dev(4'ha, 1'b0), 2'd0);
            if (i == 1) xfer(8'h22, 2'd0);
            u_fr.pulse(1);
            repeat (4) @(posedge i_clk);
            #1;
            check(busy, 1'b0);
        end
        wr_start(4'ha, 8'h13);
        for (i = 0; i < 9; i++) xfer(8'h20 + i[7:0], 2'd0);
        prog();
        done("abort and page write");
        u_fr.pulse(0);
        xfer({4'ha, slave_addr ^ 3'h1, 1'b0}, 2'd2);
        xfer(8'h10, 2'd2);
        u_fr.pulse(0);
        xfer(dev(4'h3, 1'b0), 2'd2);
        u_fr.pulse(1);
        // Later tests answer to a different preset address.
        slave_addr = 3'h2;
        done("refusals");
        for (i = 0; i < 6; i++) begin
            u_fr.pulse(0);
            xfer(dev(SPD[i][6:3], SPD[i][2]), {1'b0, SPD[i][1]});
            u_fr.pulse(1);
            check(hs, SPD[i][0]);
        end
        done("speed");
        cmd(4'h7, 8'h02, 8'h01, 2'd0);
        check(zone_ro, 4'h4);
        cmd(4'h1, 8'h00, 8'h00, 2'd3);
        check(frozen, 1'b1);
        cmd(4'h7, 8'h00, 8'h01, 2'd3);
        check(zone_ro, 4'h4);
        cmd(4'hb, 8'h10, 8'ha5, 2'd0);
        cmd(4'hb, 8'h05, 8'ha5, 2'd1);
        cmd(4'h2, 8'h60, 8'h00, 2'd0);
        check(locked, 1'b1);
        cmd(4'hb, 8'h10, 8'ha5, 2'd1);
        done("zones and lock");
        for (i = 0; i < 3; i++) begin
            {saw_id, saw_rd, rd_sec} = 3'b000;
            u_fr.pulse(0);
            xfer(dev(RDT[i][6:3], 1'b1), 2'd0);
            repeat (2) @(posedge i_clk);
            #1;
            check({saw_id, saw_rd, rd_sec}, RDT[i][2:0]);
            u_fr.pulse(1);
        end
        check(read_addr, 8'h10);
        done("reads");
        wr_start(4'ha, 8'h30);
        xfer(8'h77, 2'd0);
        u_fr.pulse(1);
        u_fr.line_low(10);
        check(busy, 1'b0);
        check(corrupt, 1'b1);
        done("discharge");
        end_of_test();
    end
endmodule // single_wire_eeprom_opcode_write_bench
